// ---- core/rsq_top.sv ----
// ring signal qualifier with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_top #(
  parameter int unsigned CLK_HZ      = 20000000,
  parameter int unsigned TICK_CYCLES =
    CLK_HZ / `RSQ_MS_PER_S * `RSQ_TICK_MS
) (
  // clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  // avalon-mm slave
  input  wire rsq_pkg::rsq_avs_req_type AVS_REQ,
  output var  logic [31:0]              AVS_READDATA,
  output var  logic                     AVS_WAITREQUEST,
  // ring detector
  input  wire logic                     LINE_EVENT,
  // ring indication
  output var  logic                     RING_VALID,
  output var  logic                     RING_ACTIVE,
  output var  logic                     IRQ
);
  import rsq_pkg::*;

  // =============================================================
  // code to tick count lookups

  function automatic logic [9:0] ms_to_ticks(input int unsigned ms);
    ms_to_ticks = 10'(ms / `RSQ_TICK_MS);
  endfunction

  function automatic logic [9:0] confirm_ticks(input logic [2:0] code);
    case (code)
      3'h0:    confirm_ticks = ms_to_ticks(`RSQ_CONF_MS_0);
      3'h1:    confirm_ticks = ms_to_ticks(`RSQ_CONF_MS_1);
      3'h2:    confirm_ticks = ms_to_ticks(`RSQ_CONF_MS_2);
      3'h3:    confirm_ticks = ms_to_ticks(`RSQ_CONF_MS_3);
      3'h4:    confirm_ticks = ms_to_ticks(`RSQ_CONF_MS_4);
      3'h5:    confirm_ticks = ms_to_ticks(`RSQ_CONF_MS_5);
      3'h6:    confirm_ticks = ms_to_ticks(`RSQ_CONF_MS_6);
      default: confirm_ticks = ms_to_ticks(`RSQ_CONF_MS_7);
    endcase
  endfunction

  // linear steps between the printed endpoints
  function automatic logic [9:0] delay_ticks(input logic [2:0] code);
    delay_ticks = 10'({7'h00, code} * ms_to_ticks(`RSQ_DELAY_STEP_MS));
  endfunction

  function automatic logic [9:0] timeout_ticks(input logic [3:0] code);
    if (code == 4'h0) begin
      timeout_ticks = ms_to_ticks(`RSQ_TMO_MS_0);
    end else begin
      timeout_ticks = 10'({6'h00, code} * ms_to_ticks(`RSQ_TMO_STEP_MS));
    end
  endfunction

  // =============================================================
  // time base

  logic tick;

  // fixed crystal-derived step keeps the frequency bound well inside 10%
  rsq_tick #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .CLK   (CLK),
    .RST_N (RST_N),
    .TICK  (tick)
  );

  // =============================================================
  // state

  rsq_state_type st;
  rsq_state_type next_st;

  logic       line_evt;
  logic [5:0] idx;
  logic       bus_do_write;
  logic [2:0] delay_code;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic       too_fast;
  logic       timed_out;
  logic       phase_done;

  always_comb begin
    line_evt     = st.sync2 & ~st.sync3;
    idx          = AVS_REQ.address[`RSQ_IDX_MSB:`RSQ_IDX_LSB];
    bus_do_write = AVS_REQ.write & ~st.waitrequest;
    delay_code   = {st.ctrl2.ring_delay_msb, st.ctrl1.ring_delay_low};
    // a timer still above the limit means the crossings came too close
    too_fast     = st.seen_prev
                   && (st.qual_timer > st.ctrl1.max_freq_limit);
    timed_out    = tick && (st.timeout_count <= 10'h001);
    phase_done   = tick && (st.phase_count <= 10'h001);
  end

  // =============================================================
  // next state

  always_comb begin
    next_st = st;
    ev_set  = 3'h0;
    ev_clr  = 3'h0;

    // pin synchroniser, sync1 feeds sync2 only
    next_st.sync1 = LINE_EVENT;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    // ---- qualification timer, 2 ms steps, stops at zero
    if (tick && (st.qual_timer != 6'h00)) begin
      next_st.qual_timer = st.qual_timer - 6'h01;
    end

    // ---- ring-end timeout and phase counters
    if (tick && (st.timeout_count != 10'h000)) begin
      next_st.timeout_count = st.timeout_count - 10'h001;
    end
    if (tick && (st.phase_count != 10'h000)) begin
      next_st.phase_count = st.phase_count - 10'h001;
    end

    // each crossing restarts the end-of-ring timeout
    if (line_evt) begin
      next_st.timeout_count =
        timeout_ticks(st.ctrl2.ring_timeout_code);
    end

    // ---- ring sequence
    case (st.ring)
      RSQ_IDLE: begin
        if (line_evt) begin
          next_st.seen_prev  = 1'b1;
          next_st.qual_timer = st.ctrl3.assert_time;
          if (st.ctrl3.qualify_enable) begin
            next_st.ring        = RSQ_CONFIRM;
            next_st.phase_count =
              confirm_ticks(st.ctrl2.confirm_time_code);
          end else begin
            // bypass: every crossing is a ring at once
            next_st.ring = RSQ_VALID;
            ev_set[`RSQ_ST_VALID] = 1'b1;
          end
        end
      end

      RSQ_CONFIRM: begin
        if (line_evt && too_fast) begin
          next_st.ring      = RSQ_IDLE;
          next_st.seen_prev = 1'b0;
          ev_set[`RSQ_ST_INVALID] = 1'b1;
        end else if (timed_out && !line_evt) begin
          next_st.ring      = RSQ_IDLE;
          next_st.seen_prev = 1'b0;
        end else if (phase_done) begin
          if (delay_code == 3'h0) begin
            next_st.ring = RSQ_VALID;
            ev_set[`RSQ_ST_VALID] = 1'b1;
          end else begin
            next_st.ring        = RSQ_DELAY;
            next_st.phase_count = delay_ticks(delay_code);
          end
        end
        if (line_evt) begin
          next_st.qual_timer = st.ctrl3.assert_time;
        end
      end

      RSQ_DELAY: begin
        if (line_evt && too_fast) begin
          next_st.ring      = RSQ_IDLE;
          next_st.seen_prev = 1'b0;
          ev_set[`RSQ_ST_INVALID] = 1'b1;
        end else if (timed_out && !line_evt) begin
          next_st.ring      = RSQ_IDLE;
          next_st.seen_prev = 1'b0;
        end else if (phase_done) begin
          next_st.ring = RSQ_VALID;
          ev_set[`RSQ_ST_VALID] = 1'b1;
        end
        if (line_evt) begin
          next_st.qual_timer = st.ctrl3.assert_time;
        end
      end

      RSQ_VALID: begin
        if (timed_out && !line_evt) begin
          next_st.ring      = RSQ_IDLE;
          next_st.seen_prev = 1'b0;
          ev_set[`RSQ_ST_END] = 1'b1;
        end
        if (line_evt) begin
          next_st.qual_timer = st.ctrl3.assert_time;
        end
      end

      default: begin
        next_st.ring      = RSQ_IDLE;
        next_st.seen_prev = 1'b0;
      end
    endcase

    // disabling mid-ring drops back to the bypass path
    if (!st.ctrl3.qualify_enable
        && ((st.ring == RSQ_CONFIRM) || (st.ring == RSQ_DELAY))) begin
      next_st.ring = RSQ_IDLE;
      next_st.seen_prev = 1'b0;
    end

    // ---- register writes, taken on the edge that ends the answer cycle, one edge after the wait
    if (bus_do_write) begin
      case (idx)
        `RSQ_IDX_CTRL1: begin
          next_st.ctrl1 = AVS_REQ.writedata[7:0];
        end
        `RSQ_IDX_CTRL2: begin
          next_st.ctrl2 = AVS_REQ.writedata[7:0];
        end
        `RSQ_IDX_CTRL3: begin
          next_st.ctrl3 = AVS_REQ.writedata[7:0];
        end
        `RSQ_IDX_STATUS: begin
          ev_clr = AVS_REQ.writedata[`RSQ_ST_WIDTH-1:0];
        end
        `RSQ_IDX_MASK: begin
          next_st.mask = AVS_REQ.writedata[`RSQ_ST_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end

    // set wins over a clear in the same cycle
    next_st.status = (st.status & ~ev_clr) | ev_set;

    // ---- bus handshake: one wait cycle, then answer
    next_st.waitrequest = 1'b1;
    if ((AVS_REQ.read || AVS_REQ.write) && st.waitrequest) begin
      next_st.waitrequest = 1'b0;
    end
    if (AVS_REQ.read && st.waitrequest) begin
      case (idx)
        `RSQ_IDX_CTRL1: begin
          next_st.readdata = {24'h000000, st.ctrl1};
        end
        `RSQ_IDX_CTRL2: begin
          next_st.readdata = {24'h000000, st.ctrl2};
        end
        `RSQ_IDX_CTRL3: begin
          next_st.readdata = {24'h000000, st.ctrl3};
        end
        `RSQ_IDX_STATUS: begin
          next_st.readdata = {29'h00000000, st.status};
        end
        `RSQ_IDX_MASK: begin
          next_st.readdata = {29'h00000000, st.mask};
        end
        `RSQ_IDX_STATE: begin
          next_st.readdata = {24'h000000, st.ring, st.qual_timer};
        end
        default: begin
          next_st.readdata = 32'h00000000;
        end
      endcase
    end

    // ---- registered outputs
    next_st.ring_valid  = (next_st.ring == RSQ_VALID);
    next_st.ring_active = (next_st.ring != RSQ_IDLE);
    next_st.irq         = |(next_st.status & next_st.mask);
  end

  // =============================================================
  // state register

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st             <= '0;
      st.waitrequest <= 1'b1;
      st.ring        <= RSQ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // =============================================================
  // outputs

  assign AVS_READDATA    = st.readdata;
  assign AVS_WAITREQUEST = st.waitrequest;
  assign RING_VALID      = st.ring_valid;
  assign RING_ACTIVE     = st.ring_active;
  assign IRQ             = st.irq;
endmodule
`default_nettype wire

// ---- core/rsq_regs.svh ----
// register map, field positions and timing figures of the ring qualifier
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH

// =============================================================
// register indices, byte address is four times the index
`define RSQ_IDX_CTRL1      6'h16
`define RSQ_IDX_CTRL2      6'h17
`define RSQ_IDX_CTRL3      6'h18
`define RSQ_IDX_STATUS     6'h19
`define RSQ_IDX_MASK       6'h1A
`define RSQ_IDX_STATE      6'h1B
`define RSQ_IDX_LSB        2
`define RSQ_IDX_MSB        7

// =============================================================
// status bit positions
`define RSQ_ST_VALID       0
`define RSQ_ST_INVALID     1
`define RSQ_ST_END         2
`define RSQ_ST_WIDTH       3

// =============================================================
// timing figures in ms
`define RSQ_TICK_MS        2
`define RSQ_MS_PER_S       1000
`define RSQ_CONF_MS_0      100
`define RSQ_CONF_MS_1      150
`define RSQ_CONF_MS_2      200
`define RSQ_CONF_MS_3      256
`define RSQ_CONF_MS_4      384
`define RSQ_CONF_MS_5      512
`define RSQ_CONF_MS_6      640
`define RSQ_CONF_MS_7      1024
`define RSQ_DELAY_STEP_MS  256
`define RSQ_TMO_MS_0       80
`define RSQ_TMO_STEP_MS    128

`endif

// ---- core/rsq_pkg.sv ----
// types shared by the ring qualifier
package rsq_pkg;

  typedef enum logic [1:0] {
    RSQ_IDLE    = 2'b00,
    RSQ_CONFIRM = 2'b01,
    RSQ_DELAY   = 2'b10,
    RSQ_VALID   = 2'b11
  } rsq_ring_type;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } rsq_avs_req_type;

  typedef struct packed {
    logic [1:0] ring_delay_low;
    logic [5:0] max_freq_limit;
  } rsq_ctrl1_type;

  typedef struct packed {
    logic       ring_delay_msb;
    logic [3:0] ring_timeout_code;
    logic [2:0] confirm_time_code;
  } rsq_ctrl2_type;

  typedef struct packed {
    logic       qualify_enable;
    logic       spare;
    logic [5:0] assert_time;
  } rsq_ctrl3_type;

  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          sync3;
    rsq_ctrl1_type ctrl1;
    rsq_ctrl2_type ctrl2;
    rsq_ctrl3_type ctrl3;
    logic [2:0]    status;
    logic [2:0]    mask;
    rsq_ring_type  ring;
    logic          seen_prev;
    logic [5:0]    qual_timer;
    logic [9:0]    phase_count;
    logic [9:0]    timeout_count;
    logic          waitrequest;
    logic [31:0]   readdata;
    logic          ring_valid;
    logic          ring_active;
    logic          irq;
  } rsq_state_type;

endpackage

// ---- core/rsq_tick.sv ----
// free-running tick generator for the qualifier time base
`timescale 1ns/1ps
`default_nettype none
module rsq_tick #(
  parameter int unsigned PERIOD = 40000
) (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST_N,
  // one-cycle pulse every PERIOD cycles
  output var  logic TICK
);
  localparam int unsigned W = $clog2(PERIOD + 1);

  typedef struct packed {
    logic [W-1:0] count;
    logic         tick;
  } rsq_tick_state_type;

  rsq_tick_state_type st;
  rsq_tick_state_type next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count == W'(PERIOD - 1)) begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + W'(1);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign TICK = st.tick;
endmodule
`default_nettype wire

// ---- sim/rsq_top_checker.sv ----
// port-level assertions for the ring qualifier
`timescale 1ns/1ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_top_checker
  import rsq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 40000
) (
  // watched ports
  input wire logic                     CLK,
  input wire logic                     RST_N,
  input wire rsq_pkg::rsq_avs_req_type AVS_REQ,
  input wire logic [31:0]              AVS_READDATA,
  input wire logic                     AVS_WAITREQUEST,
  input wire logic                     LINE_EVENT,
  input wire logic                     RING_VALID,
  input wire logic                     RING_ACTIVE,
  input wire logic                     IRQ
);
  logic        en;
  logic [31:0] act_cnt;
  logic [31:0] quiet_cnt;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ==========================================================
  // shadow of the enable bit and two cycle counters
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en <= 1'b0;
      act_cnt <= 32'h0;
      quiet_cnt <= 32'h0;
    end else begin
      if (AVS_REQ.write && !AVS_WAITREQUEST &&
          AVS_REQ.address[7:2] == `RSQ_IDX_CTRL3) begin
        en <= AVS_REQ.writedata[7];
      end
      act_cnt <= RING_ACTIVE ? act_cnt + 32'h1 : 32'h0;
      quiet_cnt <= LINE_EVENT ? 32'h0 : quiet_cnt + 32'h1;
    end
  end

  // ==========================================================
  // assertions
  a_wait_one_cycle: assert property (
    $fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST) else $error("long answer");
  a_wait_answer: assert property (
    (AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer");
  a_read_width: assert property (
    AVS_REQ.read && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("high read bits set");
  a_valid_active: assert property (
    RING_VALID |-> RING_ACTIVE) else $error("valid while idle");
  a_active_cause: assert property (
    $rose(RING_ACTIVE) |-> $past(LINE_EVENT, 2) || $past(LINE_EVENT, 3) ||
    $past(LINE_EVENT, 4)) else $error("ring without event");
  a_confirm_min: assert property (
    $rose(RING_VALID) && en |-> act_cnt >= 49 * TICK_CYCLES - 1)
    else $error("confirmed too early");
  a_bypass_direct: assert property (
    $rose(RING_ACTIVE) && !en |-> RING_VALID) else $error("bypass delayed");
  a_timeout_min: assert property (
    $fell(RING_VALID) |-> quiet_cnt >= 39 * TICK_CYCLES - 8)
    else $error("ring ended early");
  // interrupt only drops after software clears status or mask
  a_irq_release: assert property (
    $fell(IRQ) |-> $past(AVS_REQ.write && !AVS_WAITREQUEST &&
    (AVS_REQ.address[7:2] == `RSQ_IDX_STATUS ||
     AVS_REQ.address[7:2] == `RSQ_IDX_MASK)))
    else $error("interrupt dropped without a write");
endmodule

bind rsq_top rsq_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
  .CLK(CLK), .RST_N(RST_N), .AVS_REQ(AVS_REQ),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .LINE_EVENT(LINE_EVENT), .RING_VALID(RING_VALID),
  .RING_ACTIVE(RING_ACTIVE), .IRQ(IRQ));
`default_nettype wire

// ---- sim/rsq_line_model.sv ----
// behavioural ring detector producing line-crossing events
`timescale 1ns/1ps
`default_nettype none
module rsq_line_model (
  // clock
  input wire logic CLK,
  // detector output, idles low
  output var logic LINE_EVENT
);
  initial LINE_EVENT = 1'b0;
  // held 4 cycles so the two-stage synchroniser never misses it
  task automatic ring(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      LINE_EVENT <= 1'b1;
      repeat (4) @(posedge CLK);
      LINE_EVENT <= 1'b0;
      repeat (gap - 5) @(posedge CLK);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/rsq_top_tb_top.sv ----
// self-checking bench for the ring signal qualifier
`timescale 1ns/1ps
`default_nettype none
module rsq_top_tb_top;
  import rsq_pkg::*;
  // short tick keeps every ring time a few thousand cycles
  localparam int unsigned T = 8;
  logic            clk;
  logic            rst_n;
  rsq_avs_req_type req;
  logic [31:0]     rdata;
  logic            wreq;
  logic            ev;
  logic            valid;
  logic            active;
  logic            irq;
  logic [7:0]      q;
  int              n_errors;
  int              num_checks;
  int              cycles;

  rsq_top #(.TICK_CYCLES(T)) dut (.CLK(clk), .RST_N(rst_n),
    .AVS_REQ(req), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .LINE_EVENT(ev), .RING_VALID(valid), .RING_ACTIVE(active), .IRQ(irq));
  rsq_line_model line (.CLK(clk), .LINE_EVENT(ev));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wait_t(input int n);
    repeat (n * T) @(negedge clk);
  endtask
  task automatic bus(input logic [5:0] idx, input logic wr,
                     input logic [31:0] d);
    @(posedge clk);
    req.address <= {idx, 2'b00};
    req.read <= ~wr;
    req.write <= wr;
    req.writedata <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] c1, c2, c3, m);
    bus(6'h16, 1'b1, {24'h0, c1});
    bus(6'h17, 1'b1, {24'h0, c2});
    bus(6'h18, 1'b1, {24'h0, c3});
    bus(6'h19, 1'b1, 32'h7);
    bus(6'h1A, 1'b1, {24'h0, m});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] pat [2] = '{8'h5A, 8'hA5};
    bus(6'h17, 1'b0, 32'h0);
    chk8(q, 8'h00);
    for (int i = 0; i < 2; i++) begin
      bus(6'h17, 1'b1, {24'hFFFFFF, pat[i]});
      bus(6'h17, 1'b0, 32'h0);
      chk8(q, pat[i]);
      bus(6'h16, 1'b1, {24'hFFFFFF, ~pat[i]});
      bus(6'h16, 1'b0, 32'h0);
      chk8(q, ~pat[i]);
    end
    bus(6'h3F, 1'b1, 32'hFF);
    bus(6'h3F, 1'b0, 32'h0);
    chk8(q, 8'h00);
    $display("regs done");
  endtask
  task automatic t_valid;
    cfg(8'h0A, 8'h00, 8'h94, 8'h07);
    fork
      line.ring(6, 12 * T);
      begin
        wait_t(47);
        chk1(valid, 1'b0);
        wait_t(6);
        chk1(valid, 1'b1);
      end
    join
    wait_t(25);
    chk1(valid, 1'b1);
    wait_t(6);
    chk1(valid, 1'b0);
    chk1(irq, 1'b1);
    bus(6'h19, 1'b0, 32'h0);
    chk8(q, 8'h05);
    bus(6'h19, 1'b1, 32'h5);
    wait_t(1);
    chk1(irq, 1'b0);
    $display("valid ring done");
  endtask
  task automatic t_times;
    logic [7:0] c1 [4] = '{8'h4A, 8'hCA, 8'h0A, 8'h8A};
    logic [7:0] c2 [4] = '{8'h78, 8'hF8, 8'h7F, 8'h7C};
    int exp [4] = '{178, 946, 512, 448};
    for (int i = 0; i < 4; i++) begin
      cfg(c1[i], c2[i], 8'h94, 8'h00);
      line.ring(1, 8);
      bus(6'h1B, 1'b0, 32'h0);
      chk1(q[7:6] == 2'b01 && q[5:0] >= 6'h12, 1'b1);
      wait_t(exp[i] - 4);
      chk1(valid, 1'b0);
      wait_t(4);
      chk1(valid, 1'b1);
      bus(6'h1B, 1'b0, 32'h0);
      chk8(q, 8'hC0);
      wait_t(956 - exp[i]);
      chk1(valid, 1'b1);
      wait_t(6);
      chk1(active, 1'b0);
    end
    $display("timing codes done");
  endtask
  task automatic t_fast;
    cfg(8'h0A, 8'h00, 8'h94, 8'h00);
    line.ring(2, 4 * T);
    wait_t(1);
    chk1(active, 1'b0);
    chk1(irq, 1'b0);
    bus(6'h19, 1'b0, 32'h0);
    chk8(q, 8'h02);
    bus(6'h1A, 1'b1, 32'h2);
    wait_t(1);
    chk1(irq, 1'b1);
    bus(6'h19, 1'b1, 32'h2);
    wait_t(1);
    chk1(irq, 1'b0);
    $display("fast ring done");
  endtask
  task automatic t_bypass;
    cfg(8'h0A, 8'h00, 8'h14, 8'h00);
    line.ring(1, 8);
    wait_t(1);
    chk1(valid, 1'b1);
    wait_t(45);
    chk1(active, 1'b0);
    $display("bypass done");
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    req = '0;
    cycles = 0;
    n_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk1(wreq, 1'b1);
    chk1(active, 1'b0);
    t_regs;
    t_valid;
    t_times;
    t_fast;
    t_bypass;
    results();
  end
endmodule
`default_nettype wire
